// ### design/dcs_device.sv
// Purpose: controller end of the disk command sequencer
// Assumes: drive side answers each request with one resp pulse
// Notes: sector buffer held as flops; one byte per cycle to the drive
// What this block does
// - set init-done status after any initialization
// - command parity fault: parity bit, abort, error, done
// - read CRC mismatch: CRC bit, error, done
// - parameters identified only by arrival order
// - fill: request word count, then address
// - fill: DMA words in, zero pad, then done
// - interrupt when done rises with enable set, except on power loss
// - status word left in data register at end
// - buffer functions ignore unit; density checks count
// - empty: same handshake, buffer out unchanged
// - sector functions request sector then track address
// - seek without request; density mismatch aborts
// - write mark, sector bytes, two CRC bytes
// - no track code 150, no sector code 70
// - write keeps buffer; init clears it
// - write to sector 152 or 153 turns into track format
// - read: handshake, seek, mark, load sector bytes
// - read good only on zero CRC residue
// - deleted mark sets deleted-data status bit
// - read end: status to data register, done
// - host picks function bits 3-1, launches with bit 0
// - host keeps track 0-76, sector 1-26
// - word count above sector size: overflow, error
// - new function clears status except unit, density
`timescale 1ns/1ps
module dcs_device
    import dcs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // host link
    dcs_if.dev bus,
    // controller events
    input wire logic par_fault_in,
    input wire logic pwr_fail_in,
    // drive side
    output logic drv_go_out,
    output logic [1:0] drv_op_out,
    output logic drv_unit_out,
    output logic [7:0] drv_track_out,
    output logic [7:0] drv_sector_out,
    input wire logic drv_resp_in,
    input wire logic [1:0] drv_code_in,
    input wire logic drv_media_den_in,
    output logic wr_valid_out,
    output logic [7:0] wr_byte_out,
    input wire logic rd_valid_in,
    input wire logic [7:0] rd_byte_in
);
    typedef enum logic [11:0] {
        S_IDLE = 12'h001, S_INIT = 12'h002, S_P1 = 12'h004, S_SHIFT = 12'h008,
        S_P2 = 12'h010, S_DMA = 12'h020, S_PAD = 12'h040, S_DRIVE = 12'h080,
        S_WRITE = 12'h100, S_READ = 12'h200, S_FIN = 12'h400, S_PWR = 12'h800
    } dcs_state_t;

    typedef struct packed {
        dcs_state_t st;
        logic recording_mode_bit;
        logic ie;
        logic unit;
        logic tr;
        logic dn;
        logic er;
        logic [2:0] fn;
        logic par_chk;
        logic fmt;
        logic mark_seen;
        logic [15:0] es;
        logic [15:0] db;
        logic [7:0] ercode;
        logic [15:0] wc;
        logic [15:0] ba;
        logic [7:0] sa;
        logic [7:0] ta;
        logic [8:0] ptr;
        logic [3:0] cnt;
        logic [15:0] crc;
        logic dma_req;
        logic dma_we;
        logic [15:0] dma_wdata;
        logic irq;
        logic drv_go;
        logic [1:0] drv_op;
        logic wr_valid;
        logic [7:0] wr_byte;
        logic [255:0][7:0] sbuf;
    } dcs_dev_t;

    dcs_dev_t s_q, s_d;
    logic [8:0] size;
    logic drv_fn;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    assign size = s_q.recording_mode_bit ? SEC_BYTES_DD : SEC_BYTES_SD;
    assign drv_fn = s_q.fn[1];

    always_comb begin
        s_d = s_q;
        s_d.irq = 1'b0;
        s_d.drv_go = 1'b0;
        case (s_q.st)
            S_IDLE: begin
                if (bus.cmd_wr) begin
                    s_d.recording_mode_bit = bus.cmd_wdata[CS_DEN];
                    s_d.ie = bus.cmd_wdata[CS_IE];
                    s_d.unit = bus.cmd_wdata[CS_UNIT];
                    if (bus.cmd_wdata[CS_EX]) begin
                        s_d.fn = bus.cmd_wdata[CS_FN_LO +: 3];
                        s_d.es = s_q.es & ES_KEEP_MASK;
                        s_d.ercode = 8'h00;
                        s_d.dn = 1'b0;
                        s_d.er = 1'b0;
                        s_d.par_chk = 1'b1;
                        s_d.tr = ~bus.cmd_wdata[CS_FN_LO + 2];
                        s_d.st = bus.cmd_wdata[CS_FN_LO + 2] ? S_FIN : S_P1;
                    end
                end
            end
            S_P1: begin
                s_d.par_chk = 1'b0;
                if (s_q.par_chk && par_fault_in) begin
                    s_d.es[ES_PAR] = 1'b1;
                    s_d.er = 1'b1;
                    s_d.tr = 1'b0;
                    s_d.st = S_FIN;
                end else if (bus.db_wr) begin
                    s_d.tr = 1'b0;
                    s_d.cnt = SHIFT_CYC;
                    s_d.st = S_SHIFT;
                    if (!drv_fn) begin
                        s_d.wc = bus.db_wdata;
                        if (bus.db_wdata > (s_q.recording_mode_bit ? WC_MAX_DD : WC_MAX_SD)) begin
                            s_d.es[ES_WCOV] = 1'b1;
                            s_d.er = 1'b1;
                            s_d.st = S_FIN;
                        end
                    end else begin
                        // format codes are seen before the top two bits are masked
                        s_d.fmt = (s_q.fn == FN_WRITE) && ((bus.db_wdata[7:0] == SA_FMT_SD)
                            || (bus.db_wdata[7:0] == SA_FMT_DD));
                        s_d.sa = {2'b00, bus.db_wdata[5:0]};
                    end
                end
            end
            S_SHIFT: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h1) begin
                    s_d.tr = 1'b1;
                    s_d.st = S_P2;
                end
            end
            S_P2: begin
                if (bus.db_wr) begin
                    s_d.tr = 1'b0;
                    s_d.ptr = 9'h000;
                    if (!drv_fn) begin
                        s_d.ba = {bus.db_wdata[15:1], 1'b0};
                        s_d.st = S_DMA;
                    end else begin
                        s_d.ta = bus.db_wdata[7:0];
                        s_d.drv_go = 1'b1;
                        s_d.drv_op = s_q.fmt ? DOP_FORMAT
                            : (s_q.fn == FN_READ ? DOP_READ : DOP_WRITE);
                        s_d.st = S_DRIVE;
                    end
                end
            end
            S_DMA: begin
                if (s_q.dma_req) begin
                    if (bus.dma_ack) begin
                        s_d.dma_req = 1'b0;
                        s_d.ptr = s_q.ptr + 9'h002;
                        s_d.ba = s_q.ba + 16'h0002;
                        if (bus.dma_err) begin
                            s_d.es[ES_NXM] = 1'b1;
                            s_d.er = 1'b1;
                            s_d.st = S_FIN;
                        end else if (s_q.fn == FN_FILL) begin
                            s_d.sbuf[s_q.ptr[7:0]] = bus.dma_rdata[7:0];
                            s_d.sbuf[s_q.ptr[7:0] + 8'h01] = bus.dma_rdata[15:8];
                        end
                    end
                end else if ({7'h00, s_q.ptr} == {s_q.wc[14:0], 1'b0}) begin
                    s_d.st = (s_q.fn == FN_FILL) ? S_PAD : S_FIN;
                end else begin
                    s_d.dma_req = 1'b1;
                    s_d.dma_we = (s_q.fn == FN_EMPTY);
                    s_d.dma_wdata = {s_q.sbuf[s_q.ptr[7:0] + 8'h01], s_q.sbuf[s_q.ptr[7:0]]};
                end
            end
            S_PAD: begin
                if (s_q.ptr >= size) begin
                    s_d.st = S_FIN;
                end else begin
                    s_d.sbuf[s_q.ptr[7:0]] = 8'h00;
                    s_d.ptr = s_q.ptr + 9'h001;
                end
            end
            S_DRIVE: begin
                if (drv_resp_in) begin
                    s_d.st = S_FIN;
                    if (drv_code_in == DRSP_NOTRACK) begin
                        s_d.ercode = ERRC_TRACK;
                        s_d.er = 1'b1;
                    end else if (drv_code_in == DRSP_NOSECTOR) begin
                        s_d.ercode = ERRC_SECTOR;
                        s_d.er = 1'b1;
                    end else if (!s_q.fmt && (drv_media_den_in != s_q.recording_mode_bit)) begin
                        s_d.es[ES_DENERR] = 1'b1;
                        s_d.er = 1'b1;
                    end else begin
                        s_d.es[ES_DRVDEN] = drv_media_den_in;
                        s_d.es[ES_UNIT] = s_q.unit;
                        s_d.mark_seen = 1'b0;
                        s_d.crc = CRC_INIT;
                        if (s_q.drv_op == DOP_WRITE) begin
                            s_d.wr_valid = 1'b1;
                            s_d.wr_byte = MARK_DATA;
                            s_d.crc = crc_byte(CRC_INIT, MARK_DATA);
                            s_d.st = S_WRITE;
                        end else if (s_q.drv_op == DOP_READ) begin
                            s_d.st = S_READ;
                        end
                    end
                end
            end
            S_WRITE: begin
                // buffer is only read here, so its contents survive the write
                s_d.ptr = s_q.ptr + 9'h001;
                if (s_q.ptr < size) begin
                    s_d.wr_byte = s_q.sbuf[s_q.ptr[7:0]];
                    s_d.crc = crc_byte(s_q.crc, s_q.sbuf[s_q.ptr[7:0]]);
                end else if (s_q.ptr == size) begin
                    s_d.wr_byte = s_q.crc[15:8];
                end else if (s_q.ptr == size + 9'h001) begin
                    s_d.wr_byte = s_q.crc[7:0];
                end else begin
                    s_d.wr_valid = 1'b0;
                    s_d.st = S_FIN;
                end
            end
            S_READ: begin
                if (rd_valid_in) begin
                    s_d.crc = crc_byte(s_q.crc, rd_byte_in);
                    if (!s_q.mark_seen) begin
                        s_d.mark_seen = 1'b1;
                        s_d.es[ES_DD] = (rd_byte_in == MARK_DEL);
                    end else begin
                        if (s_q.ptr < size) begin
                            s_d.sbuf[s_q.ptr[7:0]] = rd_byte_in;
                        end
                        s_d.ptr = s_q.ptr + 9'h001;
                        if (s_q.ptr == size + 9'h001) begin
                            s_d.st = S_FIN;
                            if (crc_byte(s_q.crc, rd_byte_in) != 16'h0000) begin
                                s_d.es[ES_CRC] = 1'b1;
                                s_d.er = 1'b1;
                            end
                        end
                    end
                end
            end
            S_FIN: begin
                s_d.db = s_q.es;
                s_d.dn = 1'b1;
                s_d.irq = s_q.ie;
                s_d.st = S_IDLE;
            end
            S_INIT: begin
                s_d.sbuf = '0;
                s_d.es = ES_RESET;
                s_d.es[ES_ID] = 1'b1;
                s_d.tr = 1'b0;
                s_d.er = 1'b0;
                s_d.dma_req = 1'b0;
                s_d.wr_valid = 1'b0;
                s_d.st = S_FIN;
            end
            S_PWR: begin
                if (!pwr_fail_in) begin
                    s_d.dn = 1'b0;
                    s_d.st = S_INIT;
                end
            end
            default: s_d.st = S_INIT;
        endcase
        // power loss and bus init override any function in progress
        if (pwr_fail_in && (s_q.st != S_PWR)) begin
            s_d.es[ES_PWR] = 1'b1;
            s_d.db = s_d.es;
            s_d.er = 1'b1;
            s_d.dn = 1'b1;
            s_d.tr = 1'b0;
            s_d.dma_req = 1'b0;
            s_d.wr_valid = 1'b0;
            s_d.st = S_PWR;
        end else if (bus.init_req) begin
            s_d.dn = 1'b0;
            s_d.st = S_INIT;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_q <= '0;
            s_q.st <= S_INIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.csr_rdata = {s_q.er, 6'h00, s_q.recording_mode_bit, s_q.tr, s_q.ie, s_q.dn, s_q.unit, 4'h0};
    assign bus.db_rdata = s_q.db;
    assign bus.irq = s_q.irq;
    assign bus.dma_req = s_q.dma_req;
    assign bus.dma_we = s_q.dma_we;
    assign bus.dma_addr = s_q.ba;
    assign bus.dma_wdata = s_q.dma_wdata;
    assign drv_go_out = s_q.drv_go;
    assign drv_op_out = s_q.drv_op;
    assign drv_unit_out = s_q.unit;
    assign drv_track_out = s_q.ta;
    assign drv_sector_out = s_q.sa;
    assign wr_valid_out = s_q.wr_valid;
    assign wr_byte_out = s_q.wr_byte;
endmodule

// ### design/dcs_host.sv
// Purpose: host program end, issues a function and its parameters
// Assumes: memory answers each request with one ack pulse
// Notes: parameters are written strictly in protocol order
`timescale 1ns/1ps
module dcs_host
    import dcs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // device link
    dcs_if.host bus,
    // user requests
    input wire logic go_in,
    input wire logic init_in,
    input wire logic [2:0] fn_in,
    input wire logic den_in,
    input wire logic ie_in,
    input wire logic unit_in,
    input wire logic [15:0] p1_in,
    input wire logic [15:0] p2_in,
    output logic busy_out,
    output logic done_out,
    output logic error_out,
    output logic [15:0] status_out,
    // memory port
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [15:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic mem_err_in,
    input wire logic [15:0] mem_rdata_in
);
    typedef enum logic [4:0] {
        H_IDLE = 5'h01, H_P1 = 5'h02, H_P2 = 5'h04, H_WAIT = 5'h08, H_READ = 5'h10
    } dcs_hstate_t;

    typedef struct packed {
        dcs_hstate_t st;
        logic armed;
        logic seen_low;
        logic [15:0] p2;
        logic cmd_wr;
        logic db_wr;
        logic [15:0] wdata;
        logic init_req;
        logic busy;
        logic done;
        logic error;
        logic [15:0] status;
        logic mem_req;
        logic mem_we;
        logic [15:0] mem_addr;
        logic [15:0] mem_wdata;
        logic dma_ack;
        logic dma_err;
        logic [15:0] dma_rdata;
    } dcs_host_t;

    dcs_host_t h_q, h_d;
    logic tr;
    logic fin;

    assign tr = bus.csr_rdata[CS_TR];
    assign fin = h_q.armed && (bus.csr_rdata[CS_DN] || bus.irq);

    always_comb begin
        h_d = h_q;
        h_d.cmd_wr = 1'b0;
        h_d.db_wr = 1'b0;
        h_d.done = 1'b0;
        h_d.init_req = init_in;
        if (!bus.csr_rdata[CS_DN] && h_q.busy) begin
            h_d.armed = 1'b1;
        end
        case (h_q.st)
            H_IDLE: begin
                if (go_in) begin
                    h_d.cmd_wr = 1'b1;
                    h_d.wdata = {7'h00, den_in, 1'b0, ie_in, 1'b0, unit_in, fn_in, 1'b1};
                    h_d.p2 = p2_in;
                    h_d.busy = 1'b1;
                    h_d.armed = 1'b0;
                    h_d.st = H_P1;
                end
            end
            H_P1: begin
                if (fin) begin
                    h_d.st = H_READ;
                end else if (tr && !h_q.cmd_wr) begin
                    h_d.db_wr = 1'b1;
                    h_d.wdata = p1_in;
                    h_d.seen_low = 1'b0;
                    h_d.st = H_P2;
                end
            end
            H_P2: begin
                if (!tr) begin
                    h_d.seen_low = 1'b1;
                end
                if (fin) begin
                    h_d.st = H_READ;
                end else if (h_q.seen_low && tr) begin
                    h_d.db_wr = 1'b1;
                    h_d.wdata = h_q.p2;
                    h_d.st = H_WAIT;
                end
            end
            H_WAIT: begin
                if (fin) begin
                    h_d.st = H_READ;
                end
            end
            H_READ: begin
                h_d.status = bus.db_rdata;
                h_d.error = bus.csr_rdata[CS_ER];
                h_d.done = 1'b1;
                h_d.busy = 1'b0;
                h_d.st = H_IDLE;
            end
            default: h_d.st = H_IDLE;
        endcase
        h_d.mem_req = bus.dma_req && !mem_ack_in && !h_q.dma_ack && !h_q.mem_req;
        h_d.mem_we = bus.dma_we;
        h_d.mem_addr = bus.dma_addr;
        h_d.mem_wdata = bus.dma_wdata;
        h_d.dma_ack = mem_ack_in;
        h_d.dma_err = mem_err_in;
        h_d.dma_rdata = mem_rdata_in;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            h_q <= '0;
            h_q.st <= H_IDLE;
        end else begin
            h_q <= h_d;
        end
    end

    assign bus.cmd_wr = h_q.cmd_wr;
    assign bus.cmd_wdata = h_q.wdata;
    assign bus.db_wr = h_q.db_wr;
    assign bus.db_wdata = h_q.wdata;
    assign bus.init_req = h_q.init_req;
    assign bus.dma_ack = h_q.dma_ack;
    assign bus.dma_err = h_q.dma_err;
    assign bus.dma_rdata = h_q.dma_rdata;
    assign busy_out = h_q.busy;
    assign done_out = h_q.done;
    assign error_out = h_q.error;
    assign status_out = h_q.status;
    assign mem_req_out = h_q.mem_req;
    assign mem_we_out = h_q.mem_we;
    assign mem_addr_out = h_q.mem_addr;
    assign mem_wdata_out = h_q.mem_wdata;
endmodule

// ### design/dcs_if.sv
// Purpose: register and memory link between host program and controller
// Assumes: both ends on ref_clk_in
// Notes: device drives read images and memory requests
`timescale 1ns/1ps
interface dcs_if;
    logic cmd_wr;
    logic [15:0] cmd_wdata;
    logic db_wr;
    logic [15:0] db_wdata;
    logic [15:0] csr_rdata;
    logic [15:0] db_rdata;
    logic irq;
    logic init_req;
    logic dma_req;
    logic dma_we;
    logic [15:0] dma_addr;
    logic [15:0] dma_wdata;
    logic dma_ack;
    logic dma_err;
    logic [15:0] dma_rdata;
    modport dev (input cmd_wr, cmd_wdata, db_wr, db_wdata, init_req, dma_ack, dma_err,
        dma_rdata, output csr_rdata, db_rdata, irq, dma_req, dma_we, dma_addr, dma_wdata);
    modport host (output cmd_wr, cmd_wdata, db_wr, db_wdata, init_req, dma_ack, dma_err,
        dma_rdata, input csr_rdata, db_rdata, irq, dma_req, dma_we, dma_addr, dma_wdata);
endinterface

// ### design/dcs_pkg.sv
// Purpose: shared constants and types for the disk command sequencer
// Assumes: one 20 MHz clock on both ends
// Notes: byte-wide drive stream, word-wide host memory port
package dcs_pkg;
    // command/status register fields
    localparam int CS_EX = 0;
    localparam int CS_FN_LO = 1;
    localparam int CS_UNIT = 4;
    localparam int CS_DN = 5;
    localparam int CS_IE = 6;
    localparam int CS_TR = 7;
    localparam int CS_DEN = 8;
    localparam int CS_ER = 15;
    // error/status word fields
    localparam int ES_CRC = 0;
    localparam int ES_PAR = 1;
    localparam int ES_ID = 2;
    localparam int ES_PWR = 3;
    localparam int ES_DENERR = 4;
    localparam int ES_DRVDEN = 5;
    localparam int ES_DD = 6;
    localparam int ES_UNIT = 8;
    localparam int ES_WCOV = 10;
    localparam int ES_NXM = 11;
    localparam logic [15:0] ES_KEEP_MASK = 16'h0120;
    localparam logic [15:0] ES_RESET = 16'h0000;
    localparam logic [15:0] CSR_RESET = 16'h0000;
    // function codes
    localparam logic [2:0] FN_FILL = 3'h0;
    localparam logic [2:0] FN_EMPTY = 3'h1;
    localparam logic [2:0] FN_WRITE = 3'h2;
    localparam logic [2:0] FN_READ = 3'h3;
    // limits, error codes and marks
    localparam logic [15:0] WC_MAX_SD = 16'h0040;
    localparam logic [15:0] WC_MAX_DD = 16'h0080;
    localparam logic [8:0] SEC_BYTES_SD = 9'h080;
    localparam logic [8:0] SEC_BYTES_DD = 9'h100;
    localparam logic [7:0] SA_FMT_SD = 8'h98;
    localparam logic [7:0] SA_FMT_DD = 8'h99;
    localparam logic [7:0] ERRC_TRACK = 8'h96;
    localparam logic [7:0] ERRC_SECTOR = 8'h46;
    localparam logic [7:0] MARK_DATA = 8'hfb;
    localparam logic [7:0] MARK_DEL = 8'hf8;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    // link timing: parameter shift time across the serial cable
    localparam int SHIFT_NS = 200;
    localparam int CLK_NS = 50;
    localparam logic [3:0] SHIFT_CYC = 4'((SHIFT_NS + CLK_NS - 1) / CLK_NS);
    // drive operations and answers
    localparam logic [1:0] DOP_WRITE = 2'h0;
    localparam logic [1:0] DOP_READ = 2'h1;
    localparam logic [1:0] DOP_FORMAT = 2'h2;
    localparam logic [1:0] DRSP_OK = 2'h0;
    localparam logic [1:0] DRSP_NOTRACK = 2'h1;
    localparam logic [1:0] DRSP_NOSECTOR = 2'h2;
endpackage

// ### verification/dcs_properties.sv
// Purpose: link properties of the disk command sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes: watches the interface joining the two ends
`timescale 1ns/1ps
module dcs_properties
    import dcs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // link signals
    input wire logic cmd_wr,
    input wire logic [15:0] cmd_wdata,
    input wire logic db_wr,
    input wire logic [15:0] csr_rdata,
    input wire logic irq,
    input wire logic dma_req,
    input wire logic dma_ack,
    input wire logic [15:0] dma_addr
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // only launches from idle; codes 4..7 raise no request
    property p_launch;
        cmd_wr && cmd_wdata[CS_EX] && !cmd_wdata[3] && csr_rdata[CS_DN]
            |-> ##[1:2] (!csr_rdata[CS_DN] && csr_rdata[CS_TR]);
    endproperty
    a_launch: assert property (p_launch) else $error("launch gave no request");
    property p_tr_drop;
        db_wr && csr_rdata[CS_TR] |-> ##[1:2] !csr_rdata[CS_TR];
    endproperty
    a_tr_drop: assert property (p_tr_drop) else $error("request not cleared");
    property p_dma_quiet;
        dma_req |-> !csr_rdata[CS_TR] && !csr_rdata[CS_DN];
    endproperty
    a_dma_quiet: assert property (p_dma_quiet) else $error("request or done in dma");
    property p_dma_hold;
        dma_req && !dma_ack |=> dma_req && $stable(dma_addr);
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("dma request dropped");
    property p_dma_even;
        dma_req |-> !dma_addr[0];
    endproperty
    a_dma_even: assert property (p_dma_even) else $error("odd dma address");
    property p_irq;
        irq |-> ##[0:1] (csr_rdata[CS_DN] && csr_rdata[CS_IE]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without done and enable");
    property p_irq_pulse;
        irq |=> !irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
    property p_err_dn;
        $rose(csr_rdata[CS_ER]) |-> ##[0:2] csr_rdata[CS_DN];
    endproperty
    a_err_dn: assert property (p_err_dn) else $error("error without done");
endmodule

// ### verification/tb_disk_command_sequencer.sv
// Purpose: end-to-end bench of host and device ends
// Assumes: drive and memory answered by bench processes
// Notes: results of each function checked through a queue
`timescale 1ns/1ps
module tb_disk_command_sequencer;
    import dcs_pkg::*;
    logic clk, dgo, wrv, bsy, dn, er, mreq, mwe;
    logic rst_n = 1'b0, go = 1'b0, recording_mode_bit = 1'b0, un = 1'b0, ie = 1'b1;
    logic ack = 1'b0, resp = 1'b0, rdv = 1'b0, pf = 1'b0, md = 1'b0, ini = 1'b0;
    logic [2:0] fn = 3'h0;
    logic [1:0] code = 2'h0, dop;
    logic [7:0] rdb = 8'h00, trk, sec;
    logic [15:0] p1 = 16'h0000, p2 = 16'h0000, mem_rd = 16'h0000, st, maddr, mwd;
    logic [15:0] mem [16];
    logic [16:0] exp_q[$];
    int n_mismatch = 0, checked = 0, nwr = 0, rn = 0;
    int seed = 32'haf5b52a4;
    dcs_if bus ();
    dcs_device u_dcs_device (.ref_clk_in(clk), .arst_n_in(rst_n), .bus(bus), .par_fault_in(pf),
        .pwr_fail_in(1'b0), .drv_go_out(dgo), .drv_op_out(dop), .drv_unit_out(),
        .drv_track_out(trk), .drv_sector_out(sec), .drv_resp_in(resp), .drv_code_in(code),
        .drv_media_den_in(md), .wr_valid_out(wrv), .wr_byte_out(), .rd_valid_in(rdv),
        .rd_byte_in(rdb));
    dcs_host u_dcs_host (.ref_clk_in(clk), .arst_n_in(rst_n), .bus(bus), .go_in(go),
        .init_in(ini), .fn_in(fn), .den_in(recording_mode_bit), .ie_in(ie), .unit_in(un), .p1_in(p1),
        .p2_in(p2), .busy_out(bsy), .done_out(dn), .error_out(er), .status_out(st),
        .mem_req_out(mreq), .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd),
        .mem_ack_in(ack), .mem_err_in(1'b0), .mem_rdata_in(mem_rd));
    dcs_properties u_dcs_properties (.ref_clk_in(clk), .arst_n_in(rst_n),
        .cmd_wr(bus.cmd_wr), .cmd_wdata(bus.cmd_wdata), .db_wr(bus.db_wr),
        .csr_rdata(bus.csr_rdata), .irq(bus.irq), .dma_req(bus.dma_req),
        .dma_ack(bus.dma_ack), .dma_addr(bus.dma_addr));
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run(input logic [2:0] f, input logic d, input logic [15:0] a,
        input logic [15:0] b, input logic [1:0] c, input logic [16:0] e);
        int i;
        @(negedge clk);
        {fn, recording_mode_bit, p1, p2, code, go} = {f, d, a, b, c, 1'b1};
        nwr = 0;
        exp_q.push_back(e);
        @(negedge clk);
        go = 1'b0;
        for (i = 0; i < 2000 && (bsy || exp_q.size() > 0); i++) @(negedge clk);
        if (i == 2000) begin
            n_mismatch++;
            close_out();
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // memory: one ack per request, random fill data
    always @(negedge clk) begin
        ack <= mreq;
        if (mreq && mwe) check({1'b0, mwd}, {1'b0, mem[maddr[4:1]]});
        if (mreq && !mwe) begin
            mem[maddr[4:1]] = 16'($random(seed));
            mem_rd <= mem[maddr[4:1]];
        end
    end
    // drive: answers each go; after an OK read, streams a deleted mark and zeros with a bad crc
    always @(negedge clk) begin
        resp <= dgo;
        if (resp && dop == DOP_READ && code == DRSP_OK) rn = 131;
        rdv <= rn > 0;
        rdb <= (rn == 131) ? MARK_DEL : 8'h00;
        if (rn > 0) rn--;
    end
    always @(negedge clk) if (wrv) nwr++;
    always @(negedge clk) if (dn && exp_q.size() > 0) check({er, st}, exp_q.pop_front());
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        un = 1'b1;
        run(FN_FILL, 1'b0, 16'h0002, 16'h0004, DRSP_OK, 17'h00000);
        un = 1'b0;
        run(FN_EMPTY, 1'b0, 16'h0002, 16'h0005, DRSP_OK, 17'h00000);
        run(FN_FILL, 1'b0, 16'h0041, 16'h0000, DRSP_OK, 17'h10400);
        run(FN_FILL, 1'b1, 16'h0041, 16'h0000, DRSP_OK, 17'h00000);
        run(FN_WRITE, 1'b0, 16'h0001, 16'h0000, DRSP_OK, 17'h00000);
        check(17'(nwr), 17'h00083);
        run(FN_WRITE, 1'b0, 16'h0002, 16'h004c, DRSP_NOTRACK, 17'h10000);
        check({1'b0, trk, sec}, 17'h04c02);
        run(FN_READ, 1'b0, 16'h0003, 16'h0001, DRSP_NOSECTOR, 17'h10000);
        run(FN_READ, 1'b0, 16'h001a, 16'h0005, DRSP_OK, 17'h10041);
        run(FN_WRITE, 1'b0, 16'h0098, 16'h0000, DRSP_OK, 17'h00000);
        check({15'h0000, dop}, {15'h0000, DOP_FORMAT});
        md = 1'b1;
        run(FN_WRITE, 1'b0, 16'h0001, 16'h0002, DRSP_OK, 17'h10010);
        md = 1'b0;
        pf = 1'b1;
        run(FN_FILL, 1'b0, 16'h0002, 16'h0004, DRSP_OK, 17'h10002);
        pf = 1'b0;
        ini = 1'b1;
        @(negedge clk);
        ini = 1'b0;
        repeat (4) @(negedge clk);
        check({1'b0, bus.db_rdata}, 17'h00004);
        close_out();
    end
endmodule
